// >>> core/tel_decode.sv
// Pure combinational decoder for the one-lane three-element load.
// Assumes the word on the interface comes from a register of the executor.
`timescale 1ns/1ns
module tel_decode (
  tel_dec_if.dec dec
);
  import tel_pkg::*;

  logic [3:0] ia;
  logic [1:0] size;
  logic [5:0] inc;
  logic       badBits;

  always_comb begin
    ia      = dec.word[7:4];
    size    = dec.word[11:10];
    dec.match = dec.word[31:24] == OP_TOP && dec.word[23] &&
                dec.word[21:20] == OP_LOAD && dec.word[9:8] == OP_LANE;
    dec.redirect = dec.match && size == SZ_ALL;
    dec.esize = 3'h1;
    dec.lane  = ia[3:1];
    inc       = 6'h1;
    badBits   = 1'b0;
    case (size)
      SZ_BYTE: begin
        dec.esize = 3'h1;
        dec.lane  = ia[3:1];
        inc       = 6'h1;
        badBits   = ia[0];
      end
      SZ_HALF: begin
        dec.esize = 3'h2;
        dec.lane  = {1'b0, ia[3:2]};
        inc       = ia[1] ? 6'h2 : 6'h1;
        badBits   = ia[0];
      end
      SZ_WORD: begin
        dec.esize = 3'h4;
        dec.lane  = {2'h0, ia[3]};
        inc       = ia[2] ? 6'h2 : 6'h1;
        badBits   = ia[1:0] != 2'h0;
      end
      default: begin
        badBits = 1'b0;
      end
    endcase
    dec.undef = dec.match && !dec.redirect && badBits;
    dec.d1 = {1'b0, dec.word[22], dec.word[15:12]};
    dec.d2 = dec.d1 + inc;
    dec.d3 = dec.d2 + inc;
    dec.n  = dec.word[19:16];
    dec.m  = dec.word[3:0];
    dec.wback    = dec.m != REG_PC;
    dec.regIndex = dec.m != REG_PC && dec.m != REG_INC;
    dec.unpred   = dec.match && !dec.redirect &&
                   (dec.n == REG_PC || dec.d3 > D_LAST);
  end
endmodule

// >>> core/tel_lane_load.sv
// Executor for the one-lane three-element load, with its register slave.
// Assumes operands of the base and index registers arrive with the word,
// a load port that answers each request with one ack pulse, and a vector
// register file that writes only the bytes enabled by vecBe.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module tel_lane_load (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  output logic             irq,
  input  wire logic        instValid,
  input  wire logic [31:0] instWord,
  input  wire logic [31:0] instBase,
  input  wire logic [31:0] instIndex,
  output logic             instReady,
  input  wire logic        secureState,
  input  wire logic        hypMode,
  output logic             memReq,
  output logic      [31:0] memAddr,
  output logic      [2:0]  memSize,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  output logic             vecWe,
  output logic      [4:0]  vecIdx,
  output logic      [7:0]  vecBe,
  output logic      [63:0] vecData,
  output logic             gprWe,
  output logic      [3:0]  gprIdx,
  output logic      [31:0] gprData,
  output logic      [tel_pkg::EV_W-1:0] events
);
  import tel_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_DEC, S_REQ, S_WAIT, S_WB} tel_state_e;

  tel_state_e     state;
  logic [2:0]     ctrl;
  logic [3:0]     access;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] stClr;
  logic [EV_W-1:0] next_status;
  logic [15:0]    count;
  logic [31:0]    wordQ;
  logic [31:0]    baseQ;
  logic [31:0]    indexQ;
  logic [1:0]     elem;
  logic           unknownQ;
  logic [31:0]    rdMux;
  logic           busAck;
  logic           accUndef;
  logic           accTrap;
  logic [5:0]     destSel;
  logic [4:0]     elemOfs;

  tel_dec_if decIf ();

  tel_decode uDecode (
    .dec (decIf.dec)
  );

  assign decIf.word = wordQ;

  //////////////////////////////////////////////////////////////////////////////
  // Shared arithmetic.

  function automatic logic [2:0] laneOfs(input logic [2:0] esize,
                                         input logic [2:0] lane);
    logic [5:0] prod;
    prod = {3'h0, lane} * {3'h0, esize};
    return prod[2:0];
  endfunction

  function automatic logic [7:0] laneBe(input logic [2:0] esize,
                                        input logic [2:0] lane);
    logic [7:0] base;
    base = esize == 3'h1 ? 8'h01 : (esize == 3'h2 ? 8'h03 : 8'h0f);
    return base << laneOfs(esize, lane);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register slave. Every access is answered one cycle after it is seen.

  assign busAck = !avsWaitrequest && avsByteenable[0];

  always_comb begin
    case (avsAddress)
      OFS_CTRL:   rdMux = {29'h0, ctrl};
      OFS_ACCESS: rdMux = {28'h0, access};
      OFS_STATUS: rdMux = {27'h0, status};
      OFS_MASK:   rdMux = {27'h0, mask};
      OFS_INFO:   rdMux = {21'h0, state, unknownQ, elem, 2'h0, decIf.lane};
      OFS_COUNT:  rdMux = {16'h0, count};
      default:    rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0;
    end else begin
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
      if (avsRead && avsWaitrequest) begin
        avsReaddata <= rdMux;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl   <= CTRL_RST;
      access <= ACCESS_RST;
      mask   <= '0;
    end else if (avsWrite && busAck) begin
      case (avsAddress)
        OFS_CTRL:   ctrl   <= avsWritedata[2:0];
        OFS_ACCESS: access <= avsWritedata[3:0];
        OFS_MASK:   mask   <= avsWritedata[EV_W-1:0];
        default:    ctrl   <= ctrl;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky event status. A new event wins over a clear in the same cycle.

  always_comb begin
    stClr = '0;
    if (avsWrite && busAck && avsAddress == OFS_STATUS) begin
      stClr = avsWritedata[EV_W-1:0];
    end
    next_status = (status & ~stClr) | events;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
      irq    <= 1'b0;
      count  <= 16'h0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
      if (events[EV_DONE]) begin
        count <= count + 16'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access check. A coprocessor field other than denied, with secure state or an enabled non-secure access, passes the
  // first gate; in non-secure state outside hyp mode a set trap bit then sends the load to hyp.

  always_comb begin
    accUndef = access[ACC_CP +: 2] == CP_DENIED ||
               (!secureState && !access[ACC_NS]);
    accTrap  = !accUndef && !secureState && !hypMode && access[ACC_HYP];
  end

  always_comb begin
    case (elem)
      2'h0:    destSel = decIf.d1;
      2'h1:    destSel = decIf.d2;
      default: destSel = decIf.d3;
    endcase
    case (elem)
      2'h0:    elemOfs = 5'h0;
      2'h1:    elemOfs = {2'h0, decIf.esize};
      default: elemOfs = {1'b0, decIf.esize, 1'b0};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: take a word, decide its outcome, load three elements, write
  // back the base unless the index is 15. Decoding is taken from the latched word so that the
  // decoder never sees the input bus change under it.

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state     <= S_IDLE;
      instReady <= 1'b0;
      wordQ     <= 32'h0;
      baseQ     <= 32'h0;
      indexQ    <= 32'h0;
      elem      <= 2'h0;
      unknownQ  <= 1'b0;
      events    <= '0;
      memReq    <= 1'b0;
      memAddr   <= 32'h0;
      memSize   <= 3'h1;
      vecWe     <= 1'b0;
      vecIdx    <= 5'h0;
      vecBe     <= 8'h0;
      vecData   <= 64'h0;
      gprWe     <= 1'b0;
      gprIdx    <= 4'h0;
      gprData   <= 32'h0;
    end else begin
      events <= '0;
      vecWe  <= 1'b0;
      gprWe  <= 1'b0;
      case (state)
        S_IDLE: begin
          if (instValid && instReady) begin
            wordQ     <= instWord;
            baseQ     <= instBase;
            indexQ    <= instIndex;
            instReady <= 1'b0;
            state     <= S_DEC;
          end else begin
            instReady <= ctrl[CTRL_EN];
          end
        end
        S_DEC: begin
          state    <= S_IDLE;
          elem     <= 2'h0;
          unknownQ <= 1'b0;
          // Flagged whatever the outcome unless the word decodes as undefined, so an access fault does not hide it.
          events[EV_UNPRED] <= decIf.unpred && !decIf.undef;
          if (decIf.redirect) begin
            events[EV_REDIR] <= 1'b1;
          end else if (!decIf.match || decIf.undef) begin
            events[EV_UNDEF] <= 1'b1;
          end else if (decIf.unpred &&
                       ctrl[CTRL_POL +: 2] != POL_UNKNOWN) begin
            events[EV_UNPRED] <= 1'b1;
            if (ctrl[CTRL_POL +: 2] == POL_NOP) begin
              events[EV_DONE] <= 1'b1;
            end else begin
              events[EV_UNDEF] <= 1'b1;
            end
          end else if (accUndef) begin
            events[EV_UNDEF] <= 1'b1;
          end else if (accTrap) begin
            events[EV_TRAP] <= 1'b1;
          end else begin
            events[EV_UNPRED] <= decIf.unpred;
            unknownQ          <= decIf.unpred;
            state             <= S_REQ;
          end
        end
        S_REQ: begin
          memReq  <= 1'b1;
          memAddr <= baseQ + {27'h0, elemOfs};
          memSize <= decIf.esize;
          state   <= S_WAIT;
        end
        S_WAIT: begin
          if (memAck) begin
            memReq  <= 1'b0;
            // Registers past the last one are simply not written.
            vecWe   <= destSel <= D_LAST;
            vecIdx  <= destSel[4:0];
            vecBe   <= laneBe(decIf.esize, decIf.lane);
            vecData <= {32'h0, memRdata} << {laneOfs(decIf.esize, decIf.lane), 3'h0};
            if (elem == ELEM_LAST) begin
              state <= S_WB;
            end else begin
              elem  <= elem + 2'h1;
              state <= S_REQ;
            end
          end
        end
        S_WB: begin
          gprWe  <= decIf.wback;
          gprIdx <= decIf.n;
          if (decIf.regIndex) begin
            gprData <= baseQ + indexQ;
          end else begin
            gprData <= baseQ + {28'h0, decIf.esize, 1'b0} + {29'h0, decIf.esize};
          end
          events[EV_DONE] <= 1'b1;
          state           <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  AST_REDIRECT: assert property (
    state == S_DEC && decIf.redirect |=> events[EV_REDIR] && !memReq ##1 !memReq)
    else $error("all-lanes word was not redirected");

  AST_NO_WB_15: assert property (
    gprWe |-> decIf.m != REG_PC && gprIdx == decIf.n)
    else $error("base written back for index 15");

  AST_WB_AMOUNT: assert property (
    state == S_WB && decIf.wback |=> gprWe &&
      gprData == (decIf.regIndex ? baseQ + indexQ
                                 : baseQ + 32'(3 * decIf.esize)))
    else $error("wrong writeback amount");

  AST_UNPRED: assert property (
    state == S_DEC && decIf.match && !decIf.redirect && !decIf.undef &&
      (decIf.n == REG_PC || decIf.d3 > D_LAST) |=> events[EV_UNPRED])
    else $error("unpredictable word not flagged");

  AST_NOP: assert property (
    state == S_DEC && decIf.unpred && !decIf.undef &&
      ctrl[CTRL_POL +: 2] == POL_NOP |=> events[EV_DONE] ##1 !memReq[*3])
    else $error("no-op outcome touched memory");

  AST_UNDEF_BITS: assert property (
    state == S_DEC && decIf.match && !decIf.redirect &&
      decIf.word[11:10] != SZ_WORD && decIf.word[4] |=> events[EV_UNDEF])
    else $error("index bit 0 set but not undefined");

  AST_LANE_ONLY: assert property (
    vecWe |-> vecBe == laneBe(memSize, decIf.lane) &&
      $countones(vecBe) == int'(memSize))
    else $error("bytes outside the lane written");

  AST_ADDR: assert property (
    $rose(memReq) |-> memAddr == baseQ + 32'(elem) * 32'(memSize))
    else $error("element address out of sequence");

  AST_ACCESS: assert property (
    state == S_DEC && decIf.match && !decIf.redirect && !decIf.undef &&
      !decIf.unpred && accUndef |=> events[EV_UNDEF] ##1 state == S_IDLE)
    else $error("denied access did not fault");

  AST_SPACING: assert property (
    decIf.match && decIf.word[11:10] == SZ_HALF |->
      decIf.d2 == decIf.d1 + (decIf.word[5] ? 6'h2 : 6'h1))
    else $error("halfword spacing wrong");
endmodule

// >>> shared/tel_dec_if.sv
// Decoded fields of one load word, passed from the decoder to the executor.
// Assumes the executor holds the word stable while it uses the fields.
`timescale 1ns/1ns
interface tel_dec_if;
  logic [31:0] word;
  logic        match;
  logic        redirect;
  logic        undef;
  logic        unpred;
  logic [2:0]  esize;
  logic [2:0]  lane;
  logic [5:0]  d1;
  logic [5:0]  d2;
  logic [5:0]  d3;
  logic [3:0]  n;
  logic [3:0]  m;
  logic        wback;
  logic        regIndex;
  modport dec (input word, output match, redirect, undef, unpred, esize, lane,
               d1, d2, d3, n, m, wback, regIndex);
  modport exe (output word, input match, redirect, undef, unpred, esize, lane,
               d1, d2, d3, n, m, wback, regIndex);
endinterface

// >>> shared/tel_pkg.sv
// Constants for the three-element one-lane load decoder and executor.
// Assumes a 32-bit register bus, a 32-bit load port and 64-bit vector registers.
package tel_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ACCESS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  localparam logic [7:0] OFS_INFO   = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;
  // Field positions.
  localparam int CTRL_EN   = 0;
  localparam int CTRL_POL  = 1;
  localparam int ACC_CP    = 0;
  localparam int ACC_NS    = 2;
  localparam int ACC_HYP   = 3;
  localparam int EV_DONE   = 0;
  localparam int EV_UNDEF  = 1;
  localparam int EV_TRAP   = 2;
  localparam int EV_UNPRED = 3;
  localparam int EV_REDIR  = 4;
  localparam int EV_W      = 5;
  // Reset values.
  localparam logic [2:0] CTRL_RST   = 3'h1;
  localparam logic [3:0] ACCESS_RST = 4'h3;
  // Outcome choices for unpredictable encodings, and the denied coprocessor access value.
  localparam logic [1:0] POL_UNDEF   = 2'h0;
  localparam logic [1:0] POL_NOP     = 2'h1;
  localparam logic [1:0] POL_UNKNOWN = 2'h2;
  localparam logic [1:0] CP_DENIED   = 2'h0;
  // Encoding fields.
  localparam logic [7:0] OP_TOP    = 8'hf4;
  localparam logic [1:0] OP_LOAD   = 2'h2;
  localparam logic [1:0] OP_LANE   = 2'h2;
  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] SZ_HALF   = 2'h1;
  localparam logic [1:0] SZ_WORD   = 2'h2;
  localparam logic [1:0] SZ_ALL    = 2'h3;
  localparam logic [3:0] REG_PC    = 4'hf;
  localparam logic [3:0] REG_INC   = 4'hd;
  localparam logic [5:0] D_LAST    = 6'h1f;
  localparam logic [1:0] ELEM_LAST = 2'h2;
endpackage

// >>> verification/tb_top.sv
// Self-checking bench for the one-lane three-element load executor.
// Assumes the register map and event layout of the shared package.
`timescale 1ns/1ns
module tb_top;
  import tel_pkg::*;
  logic            clock = 1'b0;
  logic            rst_b = 1'b0;
  logic [7:0]      avsAddress = 8'h0;
  logic            avsRead = 1'b0;
  logic            avsWrite = 1'b0;
  logic [31:0]     avsWritedata = 32'h0;
  logic [3:0]      avsByteenable = 4'hf;
  logic            instValid = 1'b0;
  logic [31:0]     instWord = 32'h0;
  logic [31:0]     instBase = 32'h0;
  logic [31:0]     instIndex = 32'h0;
  logic            secureState = 1'b1;
  logic            hypMode = 1'b0;
  logic            slow = 1'b0;
  logic            clrAcc = 1'b0;
  logic            avsWaitrequest, irq, instReady, memReq, memAck, vecWe, gprWe, gprSeen;
  logic [31:0]     avsReaddata, memAddr, memRdata, gprData;
  logic [2:0]      memSize;
  logic [4:0]      vecIdx;
  logic [7:0]      vecBe;
  logic [63:0]     vecData;
  logic [3:0]      gprIdx;
  logic [35:0]     gprLast;
  logic [EV_W-1:0] events, evAcc;
  logic [34:0]     addrQ [$];
  int              mismatches = 0;
  int              nCompared = 0;

  always #4 clock = ~clock;

  tel_lane_load i_tel_lane_load (
    .clock, .rst_b, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable,
    .avsReaddata, .avsWaitrequest, .irq, .instValid, .instWord, .instBase, .instIndex,
    .instReady, .secureState, .hypMode, .memReq, .memAddr, .memSize, .memAck, .memRdata,
    .vecWe, .vecIdx, .vecBe, .vecData, .gprWe, .gprIdx, .gprData, .events
  );
  tel_mem_vec_model i_model (
    .clock, .rst_b, .slow, .memReq, .memAddr, .memAck, .memRdata, .vecWe, .vecIdx, .vecBe,
    .vecData
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Events are pulses, so they are gathered here and judged after each word.
  always @(posedge clock) begin
    if (clrAcc) begin
      evAcc <= '0;
      gprSeen <= 1'b0;
      addrQ.delete();
    end else begin
      evAcc <= evAcc | events;
      if (gprWe) begin
        gprSeen <= 1'b1;
        gprLast <= {gprIdx, gprData};
      end
      if (memReq && memAck) addrQ.push_back({memSize, memAddr});
    end
  end

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    avsAddress   <= a;
    avsWritedata <= wd;
    avsWrite     <= wr;
    avsRead      <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 40);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    check("bus answer", 1, n < 40);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(w, e, x);
  endtask

  function automatic logic [31:0] enc(input logic [1:0] sz, input logic [3:0] ia,
                                      input logic [4:0] d, input logic [3:0] n,
                                      input logic [3:0] m);
    return {OP_TOP, 1'b1, d[4], 2'b10, n, d[3:0], sz, 2'b10, ia, m};
  endfunction

  task automatic exec(input logic [31:0] w, input logic [31:0] base, input logic [31:0] idx);
    int n;
    n = 0;
    @(posedge clock);
    instWord  <= w;
    instBase  <= base;
    instIndex <= idx;
    instValid <= 1'b1;
    clrAcc    <= 1'b1;
    do begin
      @(posedge clock);
      clrAcc <= 1'b0;
      n++;
    end while (instReady !== 1'b1 && n < 40);
    instValid <= 1'b0;
    // The gathered events are cleared at this edge, so look from the next one.
    @(posedge clock);
    n++;
    while ((evAcc & 5'h17) == 5'h0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
    check("finished", 1, n < 200);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_load(input logic [1:0] sz, input logic [3:0] ia, input logic [4:0] d,
                         input logic [3:0] m, input logic [31:0] idx);
    logic [63:0] old [3];
    logic [63:0] mask;
    logic [63:0] el;
    logic [31:0] base, nb;
    int e, lane, inc;
    e    = 1 << sz;
    lane = (sz == SZ_BYTE) ? ia[3:1] : (sz == SZ_HALF) ? ia[3:2] : ia[3];
    inc  = ((sz == SZ_HALF && ia[1]) || (sz == SZ_WORD && ia[2])) ? 2 : 1;
    base = 32'h2000 + {22'h0, sz, ia, 4'h0};
    nb   = (m == REG_INC) ? base + 32'(3 * e) : base + idx;
    for (int k = 0; k < 3; k++) old[k] = i_model.vregs[d + k * inc];
    exec(enc(sz, ia, d, 4'h2, m), base, idx);
    check("retire", 1 << EV_DONE, evAcc);
    check("loads", 3, addrQ.size());
    mask = ((64'h1 << (8 * e)) - 64'h1) << (8 * e * lane);
    for (int k = 0; k < 3; k++) begin
      el = 64'(i_model.memWord(base + 32'(k * e))) << (8 * e * lane);
      check("address", {3'(e), base + 32'(k * e)}, addrQ[k]);
      check("lane", (old[k] & ~mask) | (el & mask), i_model.vregs[d + k * inc]);
    end
    if (m == REG_PC) check("no writeback", 0, gprSeen);
    else check("writeback", {1'b1, 4'h2, nb}, {gprSeen, gprLast});
  endtask

  task automatic faults();
    logic [31:0] w [6];
    w = '{enc(SZ_BYTE, 4'h1, 5'h0, 4'h2, REG_PC), enc(SZ_HALF, 4'h1, 5'h0, 4'h2, REG_PC),
          enc(SZ_WORD, 4'h1, 5'h0, 4'h2, REG_PC), enc(SZ_WORD, 4'h2, 5'h0, 4'h2, REG_PC),
          enc(SZ_ALL, 4'h0, 5'h0, 4'h2, REG_PC),
          enc(SZ_BYTE, 4'h0, 5'h0, 4'h2, REG_PC) ^ 32'h200};
    for (int i = 0; i < 6; i++) begin
      exec(w[i], 32'h3000, 32'h0);
      check("fault kind", (i == 4) ? 1 << EV_REDIR : 1 << EV_UNDEF, evAcc);
      check("no load", 0, addrQ.size());
    end
  endtask

  task automatic unpredictable();
    logic [63:0] v0;
    v0 = i_model.vregs[0];
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, {29'h0, p[1:0], 1'b1});
      for (int k = 0; k < 2; k++) begin
        exec(k ? enc(SZ_BYTE, 4'h0, 5'h0, REG_PC, REG_PC)
               : enc(SZ_BYTE, 4'h0, 5'h1e, 4'h2, REG_PC), 32'h4000, 32'h0);
        check("policy", p ? 1 << EV_DONE : 1 << EV_UNDEF, evAcc & 5'h17);
        check("no load", 0, addrQ.size());
      end
    end
    wr(OFS_CTRL, 32'h5);
    exec(enc(SZ_BYTE, 4'h0, 5'h1e, 4'h2, 4'h4), 32'h4000, 32'h10);
    check("flagged", 5'h9, evAcc & 5'h9);
    check("reg 31", i_model.memWord(32'h4001) & 32'hff, i_model.vregs[31][7:0]);
    check("reg 0 kept", v0, i_model.vregs[0]);
    check("only base", {1'b1, 4'h2, 32'h4010}, {gprSeen, gprLast});
    rdchk("info", OFS_INFO, 32'hc0);
    wr(OFS_CTRL, 32'h1);
  endtask

  task automatic access();
    wr(OFS_ACCESS, 32'h0);
    exec(enc(SZ_BYTE, 4'h0, 5'h1, 4'h2, REG_PC), 32'h5000, 32'h0);
    check("denied", 1 << EV_UNDEF, evAcc);
    wr(OFS_ACCESS, 32'hf);
    secureState <= 1'b0;
    exec(enc(SZ_BYTE, 4'h0, 5'h1, 4'h2, REG_PC), 32'h5000, 32'h0);
    check("trapped", 1 << EV_TRAP, evAcc);
    hypMode <= 1'b1;
    exec(enc(SZ_BYTE, 4'h0, 5'h1, 4'h2, REG_PC), 32'h5000, 32'h0);
    check("hyp runs", 1 << EV_DONE, evAcc);
    hypMode <= 1'b0;
    secureState <= 1'b1;
    wr(OFS_ACCESS, 32'h3);
  endtask

  task automatic interrupts();
    wr(OFS_STATUS, 32'h1f);
    wr(OFS_MASK, 32'h2);
    check("irq idle", 0, irq);
    exec(32'h0, 32'h0, 32'h0);
    rdchk("status", OFS_STATUS, 32'h2);
    check("irq set", 1, irq);
    wr(OFS_MASK, 32'h0);
    repeat (2) @(posedge clock);
    check("irq masked", 0, irq);
    wr(OFS_MASK, 32'h2);
    wr(OFS_STATUS, 32'h2);
    repeat (2) @(posedge clock);
    check("irq cleared", 0, irq);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    rdchk("ctrl", OFS_CTRL, 32'h1);
    rdchk("access", OFS_ACCESS, 32'h3);
    rdchk("status", OFS_STATUS, 32'h0);
    rdchk("mask", OFS_MASK, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    do_load(SZ_BYTE, 4'ha, 5'h12, 4'h4, 32'h40);
    do_load(SZ_BYTE, 4'he, 5'h1d, REG_INC, 32'h0);
    do_load(SZ_HALF, 4'he, 5'h3, REG_INC, 32'h0);
    do_load(SZ_HALF, 4'h4, 5'h8, 4'h4, 32'hfffffff0);
    slow <= 1'b1;
    do_load(SZ_WORD, 4'hc, 5'ha, REG_PC, 32'h0);
    slow <= 1'b0;
    do_load(SZ_WORD, 4'h0, 5'h0, 4'h4, 32'h8);
    faults();
    unpredictable();
    access();
    interrupts();
    rdchk("retired", OFS_COUNT, 32'ha);
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    complete_run();
  end
endmodule

// >>> verification/tel_mem_vec_model.sv
// Behavioural load port and vector register file facing the lane load.
// Assumes one load request at a time, held until it is acknowledged.
`timescale 1ns/1ns
module tel_mem_vec_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             memAck,
  output logic      [31:0] memRdata,
  input  wire logic        vecWe,
  input  wire logic [4:0]  vecIdx,
  input  wire logic [7:0]  vecBe,
  input  wire logic [63:0] vecData
);
  logic [63:0] vregs [32];
  logic [3:0]  waitCnt;

  function automatic logic [31:0] memWord(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3a5, a[15:0] ^ 16'h1234};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Upper bytes carry junk and idle data flips, so a lazy lane select shows up.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      memAck   <= 1'b0;
      memRdata <= 32'h0;
      waitCnt  <= 4'h0;
    end else if (memReq && !memAck && waitCnt >= (slow ? 4'h5 : 4'h0)) begin
      memAck   <= 1'b1;
      memRdata <= memWord(memAddr);
      waitCnt  <= 4'h0;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      waitCnt  <= waitCnt + {3'h0, memReq && !memAck};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) vregs[i] <= 64'h0123456789abcdef ^ {8{3'h0, i[4:0]}};
    end else if (vecWe) begin
      for (int b = 0; b < 8; b++) if (vecBe[b]) vregs[vecIdx][8*b +: 8] <= vecData[8*b +: 8];
    end
  end
endmodule
